// ===== pkg/gpa_pkg.sv
// Functional notes
// - port register bits 7:4 ignore writes; they read as zero here
// - data read of an input pin returns the sampled pin level
// - data read of an output pin returns the last written latch value
// - data writes latch all four bits; output pins drive their latch
// - reset clears the data latch, makes pins inputs, pulls off
// - direction 0 is input with driver off, 1 drives and reads the latch
// - pull enable turns the pin pull on, but never while the pin is an output
// - slew enable limits output slew, no effect on input pins
// - drive select picks low or high drive, no effect on input pins
// - interrupt flag at bit 3 reads set after detection, writes ignored
// - writing 1 to acknowledge bit 2 clears the flag; it reads 0
// - interrupt enable bit 1 gates the interrupt request
// - mode bit 0 selects edge only or edge and level detection
// - edges detected synchronously: deasserted one cycle, asserted the next
// - in level mode acknowledge leaves the flag set while a pin is asserted
// - edge select 0: falling/low with pull-up; 1: rising/high with pull-down
// - pin select 1 makes its pin an interrupt source, 0 excludes it
package gpa_pkg;
  localparam int unsigned GPA_PINS = 4;
  localparam int unsigned GPA_REG_W = 8;
  localparam logic [4:0] GPA_OFS_DATA = 5'h00;
  localparam logic [4:0] GPA_OFS_DIR = 5'h04;
  localparam logic [4:0] GPA_OFS_PULL = 5'h08;
  localparam logic [4:0] GPA_OFS_SLEW = 5'h0c;
  localparam logic [4:0] GPA_OFS_DRIVE = 5'h10;
  localparam logic [4:0] GPA_OFS_SC = 5'h14;
  localparam logic [4:0] GPA_OFS_PINSEL = 5'h18;
  localparam logic [4:0] GPA_OFS_EDGESEL = 5'h1c;
  localparam int unsigned GPA_SC_MODE = 0;
  localparam int unsigned GPA_SC_IE = 1;
  localparam int unsigned GPA_SC_ACK = 2;
  localparam int unsigned GPA_SC_FLAG = 3;
  localparam logic [3:0] GPA_RST_NIB = 4'h0;
  localparam logic [31:0] GPA_RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    GPA_BUS_IDLE = 2'b00,
    GPA_BUS_ACK = 2'b01
  } gpa_bus_t;

  typedef struct packed {
    logic [3:0] data;
    logic [3:0] dir;
    logic [3:0] pull;
    logic [3:0] slew;
    logic [3:0] drive;
    logic [3:0] pinsel;
    logic [3:0] edgesel;
    logic mode;
    logic ie;
    logic flag;
  } gpa_cfg_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] pull_en;
    logic [3:0] pull_up;
    logic [3:0] slew;
    logic [3:0] drive;
  } gpa_pad_t;

  typedef struct packed {
    gpa_cfg_t cfg;
    gpa_pad_t pad;
    logic [3:0] pin_s;
    logic [3:0] act_prev;
    gpa_bus_t bus;
    logic [31:0] rdata;
    logic irq;
  } gpa_state_t;
endpackage

// ===== logic/gpa_port.sv
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module gpa_port import gpa_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic [3:0] pin_in,
  output gpa_pad_t pad,
  // interrupt
  output logic irq
);

  gpa_state_t s_q;
  gpa_state_t s_d;

  function automatic logic [31:0] nib(input logic [3:0] v);
    return {28'h0000000, v};
  endfunction

  always_comb begin
    logic [3:0] act;
    logic [3:0] edge_hit;
    logic level_hit;
    logic det;
    logic ack;
    logic wr;
    logic [3:0] wn;
    act = '0;
    edge_hit = '0;
    level_hit = 1'b0;
    det = 1'b0;
    ack = 1'b0;
    wr = 1'b0;
    wn = avs_writedata[3:0];
    s_d = s_q;
    // active-level view of each enabled pin
    act = s_q.cfg.pinsel & ~(s_q.pin_s ^ s_q.cfg.edgesel);
    edge_hit = act & ~s_q.act_prev;
    level_hit = s_q.cfg.mode & (|act);
    det = (|edge_hit) | level_hit;
    s_d.pin_s = pin_in;
    s_d.act_prev = act;
    s_d.bus = GPA_BUS_IDLE;
    s_d.rdata = GPA_RD_UNMAPPED;
    if ((avs_read || avs_write) && s_q.bus == GPA_BUS_IDLE) begin
      s_d.bus = GPA_BUS_ACK;
      if (avs_read) begin
        unique case (avs_address)
          GPA_OFS_DATA: s_d.rdata = nib((s_q.cfg.dir & s_q.cfg.data)
            | (~s_q.cfg.dir & s_q.pin_s));
          GPA_OFS_DIR: s_d.rdata = nib(s_q.cfg.dir);
          GPA_OFS_PULL: s_d.rdata = nib(s_q.cfg.pull);
          GPA_OFS_SLEW: s_d.rdata = nib(s_q.cfg.slew);
          GPA_OFS_DRIVE: s_d.rdata = nib(s_q.cfg.drive);
          GPA_OFS_SC: s_d.rdata = nib({s_q.cfg.flag, 1'b0, s_q.cfg.ie,
            s_q.cfg.mode});
          GPA_OFS_PINSEL: s_d.rdata = nib(s_q.cfg.pinsel);
          GPA_OFS_EDGESEL: s_d.rdata = nib(s_q.cfg.edgesel);
          default: s_d.rdata = GPA_RD_UNMAPPED;
        endcase
      end
    end
    // a write lands at the edge that ends its acknowledge cycle, one edge after its wait state ends
    wr = avs_write & avs_byteenable[0] & (s_q.bus == GPA_BUS_ACK);
    if (wr) begin
        unique case (avs_address)
          GPA_OFS_DATA: s_d.cfg.data = wn;
          GPA_OFS_DIR: s_d.cfg.dir = wn;
          GPA_OFS_PULL: s_d.cfg.pull = wn;
          GPA_OFS_SLEW: s_d.cfg.slew = wn;
          GPA_OFS_DRIVE: s_d.cfg.drive = wn;
          GPA_OFS_SC: begin
            s_d.cfg.ie = wn[GPA_SC_IE];
            s_d.cfg.mode = wn[GPA_SC_MODE];
            ack = wn[GPA_SC_ACK];
          end
          GPA_OFS_PINSEL: s_d.cfg.pinsel = wn;
          GPA_OFS_EDGESEL: s_d.cfg.edgesel = wn;
          default: ack = 1'b0;
        endcase
      end
    // flag: detection wins over acknowledge; level mode holds flag while asserted
    if (det) begin
      s_d.cfg.flag = 1'b1;
    end else if (ack) begin
      s_d.cfg.flag = 1'b0;
    end
    s_d.pad.oe = s_d.cfg.dir;
    s_d.pad.out = s_d.cfg.data;
    s_d.pad.pull_en = s_d.cfg.pull & ~s_d.cfg.dir;
    s_d.pad.pull_up = ~s_d.cfg.edgesel;
    s_d.pad.slew = s_d.cfg.slew & s_d.cfg.dir;
    s_d.pad.drive = s_d.cfg.drive & s_d.cfg.dir;
    s_d.irq = s_d.cfg.flag & s_d.cfg.ie;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = ~(s_q.bus == GPA_BUS_ACK);
  assign pad = s_q.pad;
  assign irq = s_q.irq;
endmodule // gpa_port

// ===== sim/gpa_port_sva.sv
`timescale 1ns/1ps
module gpa_port_chk import gpa_pkg::*; (
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input gpa_pad_t pad,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire done = !avs_waitrequest;
  wire sc_wr = avs_write && done && avs_address == GPA_OFS_SC && avs_byteenable[0];
  a_pull_out_off: assert property ((pad.pull_en & pad.oe) == 4'h0) else $error("pull on");
  a_slew_in_off: assert property ((pad.slew & ~pad.oe) == 4'h0) else $error("slew on");
  a_drive_in_off: assert property ((pad.drive & ~pad.oe) == 4'h0) else $error("drive on");
  a_rd_upper_zero: assert property (avs_read && done |-> avs_readdata[31:4] == 28'h0)
    else $error("upper bits set");
  a_ack_reads_zero: assert property (avs_read && done && avs_address == GPA_OFS_SC
    |-> !avs_readdata[GPA_SC_ACK]) else $error("ack reads 1");
  a_reset_pins_in: assert property ($rose(rst_n) |-> pad == '0) else $error("pad after reset");
  a_dir_cause: assert property ($changed(pad.oe)
    |-> $past(avs_write && done && avs_address == GPA_OFS_DIR)) else $error("oe moved");
  a_irq_ie_off: assert property (sc_wr && !avs_writedata[GPA_SC_IE] |-> ##2 !irq)
    else $error("irq with enable off");
endmodule // gpa_port_chk
bind gpa_port gpa_port_chk CHK (.*);

// ===== sim/gpa_pins.sv
`timescale 1ns/1ps
module gpa_pins import gpa_pkg::*; (
  // pad side
  input gpa_pad_t pad,
  input wire logic [3:0] ext,
  // level seen by the port
  output logic [3:0] lvl
);
  // driver wins, then the pull, then the board source
  assign lvl = pad.oe & pad.out | ~pad.oe & (pad.pull_en & pad.pull_up | ~pad.pull_en & ext);
endmodule // gpa_pins

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define CK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top import gpa_pkg::*; ;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] q;
  logic [3:0] ext = 4'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire irq;
  wire [3:0] pin_in;
  gpa_pad_t pad;
  int err_total = 0;
  int cmp_count = 0;
  gpa_port DUT (.avs_byteenable(4'hf), .*);
  gpa_pins PINS (.pad(pad), .ext(ext), .lvl(pin_in));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic rk(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    `CK("readdata", e, q)
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_io;
    ext <= 4'ha;
    bus(1'h1, GPA_OFS_DIR, 8'h35);
    bus(1'h1, GPA_OFS_DATA, 8'h35);
    rk(GPA_OFS_DIR, 32'h5);
    rk(GPA_OFS_DATA, 32'hf);
    #1;
    `CK("oe", 4'h5, pad.oe)
    `CK("out", 4'h5, pad.out & pad.oe)
    rk(5'h03, 32'h0);
  endtask
  task t_pad;
    bus(1'h1, GPA_OFS_PULL, 8'h0f);
    bus(1'h1, GPA_OFS_SLEW, 8'h0f);
    bus(1'h1, GPA_OFS_DRIVE, 8'h0f);
    bus(1'h1, GPA_OFS_EDGESEL, 8'h0f);
    repeat (2) @(posedge clk);
    #1;
    `CK("pull", 4'ha, pad.pull_en)
    `CK("slew", 4'h5, pad.slew)
    `CK("drive", 4'h5, pad.drive)
    `CK("pullup", 4'h0, pad.pull_up)
    bus(1'h1, GPA_OFS_PULL, 8'h00);
  endtask
  task t_irq;
    ext <= 4'h0;
    bus(1'h1, GPA_OFS_PINSEL, 8'h02);
    bus(1'h1, GPA_OFS_EDGESEL, 8'h02);
    bus(1'h1, GPA_OFS_SC, 8'h06);
    rk(GPA_OFS_SC, 32'h2);
    ext <= 4'h2;
    repeat (4) @(posedge clk);
    rk(GPA_OFS_SC, 32'ha);
    #1;
    `CK("irq", 1'h1, irq)
    bus(1'h1, GPA_OFS_SC, 8'h0c);
    rk(GPA_OFS_SC, 32'h0);
    #1;
    `CK("irq", 1'h0, irq)
    bus(1'h1, GPA_OFS_SC, 8'h03);
    bus(1'h1, GPA_OFS_SC, 8'h07);
    rk(GPA_OFS_SC, 32'hb);
    ext <= 4'h0;
    bus(1'h1, GPA_OFS_SC, 8'h07);
    rk(GPA_OFS_SC, 32'h3);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    for (int a = 0; a < 32; a += 4) rk(a[4:0], 32'h0);
    t_io();
    t_pad();
    t_irq();
    end_of_test();
  end
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
endmodule // tb_top
